// >>> include/irq_shadow_pkg.sv
// irq_shadow_pkg: register map, field layout, reset values and carrier types
// assumes a 32-bit apb slave on pclk, one flag/enable bank of 32 sources
package irq_shadow_pkg;

    // register byte offsets
    localparam logic [7:0] ctrl_off    = 8'h00;
    localparam logic [7:0] shadow_off  = 8'h04;
    localparam logic [7:0] status_off  = 8'h08;
    localparam logic [7:0] reload_off  = 8'h0c;
    localparam logic [7:0] flag_off    = 8'h10;
    localparam logic [7:0] enable_off  = 8'h14;
    localparam logic [7:0] evstat_off  = 8'h18;
    localparam logic [7:0] evmask_off  = 8'h1c;

    // control register fields
    localparam int multi_vector_mode_bit_pos  = 12;
    localparam int tpc_lsb   = 8;
    // shadow select fields
    localparam int lvl3_lsb  = 12;
    localparam int lvl2_lsb  = 8;
    localparam int lvl1_lsb  = 4;
    localparam int sso_pos   = 0;
    localparam logic [31:0] shadow_wmask = 32'hffff_fff1;
    // status fields
    localparam int ripl_lsb  = 8;

    // reset values
    localparam logic [31:0] reg_reset = 32'h0000_0000;

    // event bits of the sticky status register
    localparam int ev_request = 0;
    localparam int ev_timer   = 1;
    localparam int ev_width   = 2;

    // request presented to the core
    typedef struct packed {
        logic       valid;
        logic [7:0] irq;
        logic [2:0] prio;
        logic [2:0] shadow;
        logic       use_shadow;
    } core_req_t;

    // acknowledge from the core
    typedef struct packed {
        logic       ack;
        logic [7:0] irq;
    } core_ack_t;

endpackage

// >>> hw/prox_timer.sv
// prox_timer: interrupt proximity countdown timer
// assumes reload and trigger come from the pclk domain of the controller
module prox_timer (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // control
    input  wire logic        trigger,
    input  wire logic [31:0] reload,
    // state
    output logic             busy,
    output logic             expired
);
    logic [31:0] count_q;

    // load on trigger, count down to zero; retrigger while busy is ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 32'h0000_0000;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (trigger && count_q == 32'h0000_0000) begin
                count_q <= reload;
            end else if (count_q != 32'h0000_0000) begin
                count_q <= count_q - 32'h0000_0001;
                expired <= (count_q == 32'h0000_0001);
            end
        end
    end

    assign busy = (count_q != 32'h0000_0000);

endmodule // prox_timer

// >>> hw/irq_shadow_ctrl.sv
// irq_shadow_ctrl: shadow set selection, status, proximity timer and flag banks
// assumes an apb master on pclk and a core that acknowledges presented requests
module irq_shadow_ctrl (
    // clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic [31:0]                      prdata,
    output logic                             pready,
    output logic                             pslverr,
    // sources and per-source priority
    input  wire logic [31:0]                 src_event,
    input  wire logic [31:0][2:0]            src_prio,
    // core side
    output irq_shadow_pkg::core_req_t        core_req,
    input  wire irq_shadow_pkg::core_ack_t   core_ack,
    // interrupt to system
    output logic                             irq_out
);
    logic [31:0] ctrl_q, shadow_q, reload_q, flag_q, enable_q;
    logic [2:0]  ripl_q;
    logic [7:0]  last_serviced_request_field_q;
    logic [irq_shadow_pkg::ev_width-1:0] evstat_q, evmask_q, ev_set;
    logic [31:0] pending, rdata_d;
    logic        wr_en, rd_en, addr_ok;
    logic        tmr_busy, tmr_exp, tmr_trig;
    logic [4:0]  win_idx;
    logic [2:0]  win_prio;
    logic        win_valid;
    logic        multi_vector_mode_bit, defer;
    logic        win_pending;
    logic [2:0]  proximity_timer_control_field;
    irq_shadow_pkg::core_req_t req_d;

    // access decode: writes take effect in the access phase, reads are sampled in the setup phase
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !pwrite;

    // set mapping decode; reserved codes fall to set 0
    function automatic logic [2:0] set_of(input logic [3:0] code);
        set_of = code[3] ? 3'h0 : code[2:0];
    endfunction

    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a == irq_shadow_pkg::ctrl_off)   || (a == irq_shadow_pkg::shadow_off) ||
                     (a == irq_shadow_pkg::status_off) || (a == irq_shadow_pkg::reload_off) ||
                     (a == irq_shadow_pkg::flag_off)   || (a == irq_shadow_pkg::enable_off) ||
                     (a == irq_shadow_pkg::evstat_off) || (a == irq_shadow_pkg::evmask_off);
    endfunction

    assign addr_ok = known_addr(paddr);
    assign multi_vector_mode_bit    = ctrl_q[irq_shadow_pkg::multi_vector_mode_bit_pos];
    assign proximity_timer_control_field     = ctrl_q[irq_shadow_pkg::tpc_lsb +: 3];

    // control register: only mode bit and timer control are kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= irq_shadow_pkg::reg_reset;
        end else if (wr_en && paddr == irq_shadow_pkg::ctrl_off) begin
            ctrl_q <= pwdata & 32'h0000_1700;
        end
    end

    // shadow select, reserved bits masked off on write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shadow_q <= irq_shadow_pkg::reg_reset;
        end else if (wr_en && paddr == irq_shadow_pkg::shadow_off) begin
            shadow_q <= pwdata & irq_shadow_pkg::shadow_wmask;
        end
    end

    // proximity reload and enable bank
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_q <= irq_shadow_pkg::reg_reset;
            enable_q <= irq_shadow_pkg::reg_reset;
        end else if (wr_en) begin
            if (paddr == irq_shadow_pkg::reload_off) reload_q <= pwdata;
            if (paddr == irq_shadow_pkg::enable_off) enable_q <= pwdata;
        end
    end

    // flags: hardware set wins over a software write of zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= irq_shadow_pkg::reg_reset;
        end else if (wr_en && paddr == irq_shadow_pkg::flag_off) begin
            flag_q <= pwdata | src_event;
        end else begin
            flag_q <= flag_q | src_event;
        end
    end

    // pending sources, then pick highest priority, lowest index on tie
    assign pending = flag_q & enable_q;
    assign win_pending = pending[win_idx];
    always_comb begin
        win_valid = 1'b0;
        win_idx   = 5'h00;
        win_prio  = 3'h0;
        for (int i = 31; i >= 0; i--) begin
            if (pending[i] && src_prio[i] != 3'h0 && (!win_valid || src_prio[i] >= win_prio)) begin
                win_valid = 1'b1;
                win_idx   = 5'(i);
                win_prio  = src_prio[i];
            end
        end
    end

    // a low-priority winner waits while the proximity timer runs; a request already
    // presented stays up, so the one that started the timer is not pulled from the core
    assign defer    = tmr_busy && (proximity_timer_control_field != 3'h0) && (win_prio <= proximity_timer_control_field) && !core_req.valid;
    assign tmr_trig = win_valid && (proximity_timer_control_field != 3'h0) && (win_prio <= proximity_timer_control_field) && !core_req.valid;

    prox_timer u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .trigger (tmr_trig),
        .reload  (reload_q),
        .busy    (tmr_busy),
        .expired (tmr_exp)
    );

    // request to the core with shadow set selection
    always_comb begin
        req_d            = '0;
        req_d.valid      = win_valid && !defer;
        req_d.irq        = {3'h0, win_idx};
        req_d.prio       = win_prio;
        if (multi_vector_mode_bit) begin
            req_d.use_shadow = 1'b1;
            unique case (win_prio)
                3'h3:    req_d.shadow = set_of(shadow_q[irq_shadow_pkg::lvl3_lsb +: 4]);
                3'h2:    req_d.shadow = set_of(shadow_q[irq_shadow_pkg::lvl2_lsb +: 4]);
                3'h1:    req_d.shadow = set_of(shadow_q[irq_shadow_pkg::lvl1_lsb +: 4]);
                default: req_d.shadow = 3'h0;
            endcase
        end else begin
            req_d.use_shadow = shadow_q[irq_shadow_pkg::sso_pos];
            req_d.shadow     = 3'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_req <= '0;
        end else begin
            core_req <= req_d;
        end
    end

    // status: presented priority and last serviced request, read-only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ripl_q <= 3'h0;
            last_serviced_request_field_q <= 8'h00;
        end else begin
            if (req_d.valid) ripl_q <= req_d.prio;
            if (core_ack.ack) last_serviced_request_field_q <= core_ack.irq;
        end
    end

    // sticky events, write one to clear, set wins
    assign ev_set[irq_shadow_pkg::ev_request] = req_d.valid && !core_req.valid;
    assign ev_set[irq_shadow_pkg::ev_timer]   = tmr_exp;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evstat_q <= '0;
            evmask_q <= '0;
        end else begin
            if (wr_en && paddr == irq_shadow_pkg::evstat_off)
                evstat_q <= (evstat_q & ~pwdata[irq_shadow_pkg::ev_width-1:0]) | ev_set;
            else
                evstat_q <= evstat_q | ev_set;
            if (wr_en && paddr == irq_shadow_pkg::evmask_off)
                evmask_q <= pwdata[irq_shadow_pkg::ev_width-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) irq_out <= 1'b0;
        else          irq_out <= |(evstat_q & evmask_q);
    end

    // read mux; status upper bits zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (paddr)
            irq_shadow_pkg::ctrl_off:   rdata_d = ctrl_q;
            irq_shadow_pkg::shadow_off: rdata_d = shadow_q;
            irq_shadow_pkg::status_off: rdata_d = {21'h0, ripl_q, last_serviced_request_field_q};
            irq_shadow_pkg::reload_off: rdata_d = reload_q;
            irq_shadow_pkg::flag_off:   rdata_d = flag_q;
            irq_shadow_pkg::enable_off: rdata_d = enable_q;
            irq_shadow_pkg::evstat_off: rdata_d = {30'h0, evstat_q};
            irq_shadow_pkg::evmask_off: rdata_d = {30'h0, evmask_q};
            default:                    rdata_d = 32'h0000_0000;
        endcase
    end

    // no wait state: answer registered in setup, ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            if (rd_en && !penable) prdata <= rdata_d;
        end
    end

    // shadow set is zero when multi-vector mode is off
    shadow_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(multi_vector_mode_bit) |-> core_req.shadow == 3'h0)
        else $error("shadow set nonzero in single vector mode");
    sso_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(multi_vector_mode_bit) |-> core_req.use_shadow == $past(shadow_q[0]))
        else $error("single vector shadow flag wrong");
    level3_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(multi_vector_mode_bit) && core_req.valid && core_req.prio == 3'h3
        |-> core_req.shadow == set_of($past(shadow_q[15:12])))
        else $error("level 3 shadow set wrong");
    level2_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(multi_vector_mode_bit) && core_req.valid && core_req.prio == 3'h2
        |-> core_req.shadow == set_of($past(shadow_q[11:8])))
        else $error("level 2 shadow set wrong");
    level1_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(multi_vector_mode_bit) && core_req.valid && core_req.prio == 3'h1
        |-> core_req.shadow == set_of($past(shadow_q[7:4])))
        else $error("level 1 shadow set wrong");
    reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        shadow_q[3:1] == 3'h0)
        else $error("shadow reserved bits set");
    req_gated_a: assert property (@(posedge pclk) disable iff (!presetn)
        core_req.valid |-> $past(win_pending))
        else $error("request without flag and enable");
    flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        src_event[0] |=> flag_q[0])
        else $error("flag lost after event");
    ripl_track_a: assert property (@(posedge pclk) disable iff (!presetn)
        core_req.valid |-> ripl_q == core_req.prio)
        else $error("presented priority not recorded");
    last_serviced_request_field_track_a: assert property (@(posedge pclk) disable iff (!presetn)
        core_ack.ack |=> last_serviced_request_field_q == $past(core_ack.irq))
        else $error("serviced request not recorded");
    defer_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        defer |=> !core_req.valid)
        else $error("deferred interrupt presented");

    multi_vector_mode_bit_req_c:  cover property (@(posedge pclk) disable iff (!presetn) core_req.valid && multi_vector_mode_bit);
    single_c:    cover property (@(posedge pclk) disable iff (!presetn) core_req.valid && !multi_vector_mode_bit);
    timer_exp_c: cover property (@(posedge pclk) disable iff (!presetn) tmr_exp);
    irq_c:       cover property (@(posedge pclk) disable iff (!presetn) irq_out);

endmodule // irq_shadow_ctrl

// >>> testbench/core_model.sv
// core_model: behavioural processor core that services presented requests
// assumes core_req comes from the controller on pclk; one ack per presentation
module core_model #(
    parameter int ack_delay = 3
) (
    // clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // controller side
    input  wire irq_shadow_pkg::core_req_t req,
    input  wire logic                      ack_on,
    output irq_shadow_pkg::core_ack_t      ack
);
    timeunit 1ns;
    timeprecision 1ps;

    int   wait_q;
    logic done_q;

    // a slow core is modelled by the delay; the number is not held when idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= 0;
            done_q <= 1'b0;
            ack    <= '0;
        end else begin
            ack.ack <= 1'b0;
            ack.irq <= ~req.irq; // released bus shows no stale number
            if (!req.valid) begin
                wait_q <= 0;
                done_q <= 1'b0;
            end else if (ack_on && !done_q) begin
                wait_q <= wait_q + 1;
                if (wait_q == ack_delay) begin
                    ack.ack <= 1'b1;
                    ack.irq <= req.irq;
                    done_q  <= 1'b1;
                end
            end
        end
    end
endmodule // core_model

// >>> testbench/testbench.sv
// testbench: register, request, interrupt and timer checks of irq_shadow_ctrl
// assumes the package offsets and a core model that acks on request
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                      pclk, presetn, psel, penable, pwrite;
    logic                      pready, pslverr, irq_out, ack_on, err;
    logic [7:0]                paddr;
    logic [31:0]               pwdata, prdata, src_event, rd;
    logic [31:0][2:0]          src_prio;
    irq_shadow_pkg::core_req_t core_req;
    irq_shadow_pkg::core_ack_t core_ack;
    int                        err_total, checked;

    always #4 pclk = ~pclk;

    irq_shadow_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_event(src_event), .src_prio(src_prio), .core_req(core_req),
        .core_ack(core_ack), .irq_out(irq_out));
    core_model core_u (.pclk(pclk), .presetn(presetn), .req(core_req), .ack_on(ack_on), .ack(core_ack));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // one apb transfer, entered just after a rising edge; idles a cycle after
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_total++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask

    // a one-cycle event on the chosen sources
    task automatic pulse(input logic [31:0] m);
        src_event <= m;
        @(posedge pclk);
        src_event <= '0;
        @(posedge pclk);
    endtask

    // bounded wait for the presented request to reach a level
    task automatic waitv(input logic e, input string what);
        int n;
        n = 0;
        while (core_req.valid !== e && n < 60) begin
            @(posedge pclk);
            n++;
        end
        check(what, {31'h0, core_req.valid}, {31'h0, e});
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        end_of_test();
    end

    initial begin
        logic [3:0] codes [5] = '{4'h0, 4'h7, 4'h3, 4'h8, 4'hf};
        pclk = 0;
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = '0;
        pwdata = '0;
        src_event = '0;
        src_prio = '0;
        ack_on = 0;
        err_total = 0;
        checked = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 8; i++) rdc("reset value", 8'(i * 4), '0);
        wr(irq_shadow_pkg::shadow_off, 32'hffff_ffff);
        rdc("shadow select", irq_shadow_pkg::shadow_off, 32'hffff_fff1);
        wr(irq_shadow_pkg::reload_off, 32'ha5a5_5a5a);
        rdc("reload", irq_shadow_pkg::reload_off, 32'ha5a5_5a5a);
        wr(irq_shadow_pkg::enable_off, 32'h8000_0001);
        rdc("enable", irq_shadow_pkg::enable_off, 32'h8000_0001);
        wr(irq_shadow_pkg::enable_off, 32'h0);
        wr(irq_shadow_pkg::flag_off, 32'h0000_0100);
        rdc("flag", irq_shadow_pkg::flag_off, 32'h0000_0100);
        wr(irq_shadow_pkg::flag_off, 32'h0);
        wr(irq_shadow_pkg::status_off, 32'hffff_ffff);
        rdc("status", irq_shadow_pkg::status_off, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        $display("test registers done");
        // five codes (0, 7, 3, 8, f) of every low level field, multi-vector mode
        wr(irq_shadow_pkg::ctrl_off, 32'h0000_1000);
        wr(irq_shadow_pkg::enable_off, 32'h1);
        for (int l = 1; l <= 3; l++) begin
            for (int c = 0; c < 5; c++) begin
                wr(irq_shadow_pkg::shadow_off, 32'(codes[c]) << (l * 4));
                src_prio[0] <= 3'(l);
                pulse(32'h1);
                waitv(1'b1, "request raised");
                check("shadow set", 32'(core_req.shadow), codes[c][3] ? 32'h0 : 32'(codes[c][2:0]));
                check("prio", 32'(core_req.prio), 32'(l));
                check("multi uses shadow", {31'h0, core_req.use_shadow}, 32'h1);
                wr(irq_shadow_pkg::flag_off, 32'h0);
                waitv(1'b0, "request dropped");
            end
        end
        $display("test shadow fields done");
        // single-vector mode: fields ignored, status tracks presented and serviced
        wr(irq_shadow_pkg::shadow_off, 32'h0000_7771);
        wr(irq_shadow_pkg::ctrl_off, 32'h0);
        ack_on <= 1'b1;
        src_prio[5] <= 3'd6;
        src_prio[1] <= 3'd1;
        wr(irq_shadow_pkg::enable_off, 32'h20);
        pulse(32'h20);
        waitv(1'b1, "single request");
        check("single with shadow", {31'h0, core_req.use_shadow}, 32'h1);
        check("request number", 32'(core_req.irq), 32'h5);
        repeat (8) @(posedge pclk);
        rdc("status", irq_shadow_pkg::status_off, 32'h0000_0605);
        wr(irq_shadow_pkg::flag_off, 32'h0);
        waitv(1'b0, "single dropped");
        wr(irq_shadow_pkg::shadow_off, 32'h0000_7770);
        pulse(32'h20);
        waitv(1'b1, "single request");
        check("single no shadow", {31'h0, core_req.use_shadow}, 32'h0);
        check("fields ignored", 32'(core_req.shadow), 32'h0);
        wr(irq_shadow_pkg::flag_off, 32'h0);
        waitv(1'b0, "single dropped");
        ack_on <= 1'b0;
        // flag without enable must not reach the core
        wr(irq_shadow_pkg::enable_off, 32'h0);
        pulse(32'h2);
        repeat (4) @(posedge pclk);
        check("disabled source", {31'h0, core_req.valid}, 32'h0);
        rdc("flag set by event", irq_shadow_pkg::flag_off, 32'h2);
        wr(irq_shadow_pkg::enable_off, 32'h2);
        waitv(1'b1, "enabled source");
        wr(irq_shadow_pkg::flag_off, 32'h0);
        waitv(1'b0, "flag cleared");
        $display("test single vector done");
        // event status, mask and level output
        rdc("event status", irq_shadow_pkg::evstat_off, 32'h1);
        wr(irq_shadow_pkg::evmask_off, 32'h1);
        repeat (2) @(posedge pclk);
        check("irq unmasked", {31'h0, irq_out}, 32'h1);
        wr(irq_shadow_pkg::evstat_off, 32'h1);
        repeat (2) @(posedge pclk);
        check("irq cleared", {31'h0, irq_out}, 32'h0);
        rdc("event status", irq_shadow_pkg::evstat_off, 32'h0);
        wr(irq_shadow_pkg::evmask_off, 32'h0);
        pulse(32'h2);
        repeat (3) @(posedge pclk);
        check("irq masked", {31'h0, irq_out}, 32'h0);
        wr(irq_shadow_pkg::evmask_off, 32'h1);
        repeat (2) @(posedge pclk);
        check("irq unmasked late", {31'h0, irq_out}, 32'h1);
        wr(irq_shadow_pkg::flag_off, 32'h0);
        wr(irq_shadow_pkg::evstat_off, 32'h3);
        wr(irq_shadow_pkg::evmask_off, 32'h0);
        $display("test interrupt done");
        // proximity timer defers a second qualifying request
        wr(irq_shadow_pkg::reload_off, 32'd24);
        wr(irq_shadow_pkg::ctrl_off, 32'h0000_1300);
        src_prio[1] <= 3'd2;
        src_prio[2] <= 3'd2;
        wr(irq_shadow_pkg::enable_off, 32'h6);
        pulse(32'h2);
        waitv(1'b1, "first timed request");
        wr(irq_shadow_pkg::flag_off, 32'h0);
        waitv(1'b0, "first dropped");
        pulse(32'h4);
        repeat (4) @(posedge pclk);
        check("deferred", {31'h0, core_req.valid}, 32'h0);
        waitv(1'b1, "released after expiry");
        rdc("timer expiry event", irq_shadow_pkg::evstat_off, 32'h3);
        $display("test timer done");
        end_of_test();
    end
endmodule // testbench
